// ===== rtl/bib_pkg.sv
package bib_pkg;
   localparam int BIB_AW = 8;
   localparam int BIB_DW = 32;
   // Register byte addresses
   localparam logic [7:0] BIB_OPT_ADDR = 8'h20;
   localparam logic [7:0] BIB_IDHI_ADDR = 8'h24;
   localparam logic [7:0] BIB_IDLO_ADDR = 8'h28;
   localparam logic [7:0] BIB_CTRL_ADDR = 8'h2c;
   // Bus options field positions
   localparam int BIB_BMC_BIT = 28;
   localparam int BIB_PMC_BIT = 27;
   localparam int BIB_ACC_LSB = 16;
   localparam int BIB_ACC_MSB = 23;
   localparam int BIB_REC_LSB = 12;
   localparam int BIB_REC_MSB = 15;
   localparam int BIB_GEN_LSB = 6;
   localparam int BIB_GEN_MSB = 7;
   localparam int BIB_SPD_LSB = 0;
   localparam int BIB_SPD_MSB = 2;
   localparam logic [31:0] BIB_OPT_UNUSED_MASK = 32'h07000f38;
   // Control register field positions
   localparam int BIB_ROM_BIT = 0;
   localparam int BIB_HILOCK_BIT = 1;
   localparam int BIB_LOLOCK_BIT = 2;
   localparam int BIB_LINKEN_BIT = 17;
   // Reset and constant values
   localparam logic [3:0] BIB_REC_RESET = 4'ha;
   localparam logic [3:0] BIB_REC_MIN = 4'h8;
   localparam logic [2:0] BIB_LINK_SPEED = 3'h2;
   localparam logic [7:0] BIB_ACC_RESET = 8'h00;
   localparam logic [1:0] BIB_GEN_RESET = 2'h0;
   localparam logic [31:0] BIB_ID_RESET = 32'h00000000;

   typedef enum logic {BIB_ID_OPEN, BIB_ID_LOCKED} bib_id_e;

   // Largest block record in bytes for a code: 2^(code+1)
   function automatic logic [16:0] bib_rec_bytes(input logic [3:0] code);
      logic [4:0] sh;
      sh = {1'b0, code} + 5'h01;
      return 17'h00001 << sh;
   endfunction
endpackage

// ===== rtl/bib_idreg.sv
`timescale 1ns/1ns
module bib_idreg
   import bib_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic rom_mode,
   input wire logic rom_we,
   input wire logic [31:0] rom_data,
   input wire logic sw_we,
   input wire logic [31:0] sw_data,
   output logic [31:0] value,
   output logic locked
);
   bib_id_e state;
   logic take_rom;
   logic take_sw;

   // Only the source matching the detected mode may fill the register
   assign take_rom = rom_mode & rom_we & (state == BIB_ID_OPEN);
   assign take_sw = ~rom_mode & sw_we & (state == BIB_ID_OPEN);
   assign locked = (state == BIB_ID_LOCKED);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= BIB_ID_OPEN;
      end else begin
         case (state)
            BIB_ID_OPEN: begin
               if (take_rom | take_sw) begin
                  state <= BIB_ID_LOCKED;
               end
            end
            BIB_ID_LOCKED: begin
               state <= BIB_ID_LOCKED;
            end
            default: begin
               state <= BIB_ID_OPEN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         value <= BIB_ID_RESET;
      end else if (take_rom) begin
         value <= rom_data;
      end else if (take_sw) begin
         value <= sw_data;
      end
   end
endmodule // bib_idreg

// ===== rtl/bib_blkchk.sv
`timescale 1ns/1ns
module bib_blkchk
   import bib_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] max_rec,
   input wire logic blk_len_valid,
   input wire logic [15:0] blk_len,
   output logic ack_type_error
);
   logic too_long;

   assign too_long = ({1'b0, blk_len} > bib_rec_bytes(max_rec));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_type_error <= 1'b0;
      end else begin
         ack_type_error <= blk_len_valid & too_long;
      end
   end
endmodule // bib_blkchk

// ===== rtl/bib_regs.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module bib_regs
   import bib_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bib_pkg::BIB_AW-1:0] paddr,
   input wire logic [bib_pkg::BIB_DW-1:0] pwdata,
   output logic [bib_pkg::BIB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic soft_rst,
   input wire logic host_bus_rst,
   input wire logic rom_present,
   input wire logic rom_load_valid,
   input wire logic rom_load_upper,
   input wire logic [31:0] rom_load_data,
   input wire logic blk_len_valid,
   input wire logic [15:0] blk_len,
   output logic ack_type_error,
   output logic link_enable_control,
   output logic bus_manager_capable,
   output logic power_manager_capable,
   output logic [7:0] clock_accuracy,
   output logic [3:0] max_rec_code,
   output logic [1:0] generation,
   output logic [31:0] unique_id_upper_quadlet,
   output logic [31:0] unique_id_lower_quadlet,
   output logic rom_detected
);
   import bib_pkg::*;

   logic setup;
   logic acc_done;
   logic wr_done;
   logic mapped;
   logic [31:0] next_rdata;
   logic [31:0] opt_word;
   logic [31:0] ctrl_word;
   logic started;
   logic load_armed;
   logic rom_we_hi;
   logic rom_we_lo;
   logic sw_we_hi;
   logic sw_we_lo;
   logic hi_locked;
   logic lo_locked;

   assign setup = psel & ~penable;
   assign acc_done = psel & penable & pready;
   assign wr_done = acc_done & pwrite;

   assign mapped = (paddr == BIB_OPT_ADDR) | (paddr == BIB_IDHI_ADDR) |
                   (paddr == BIB_IDLO_ADDR) | (paddr == BIB_CTRL_ADDR);

   always_comb begin
      opt_word = 32'h00000000;
      opt_word[BIB_BMC_BIT] = bus_manager_capable;
      opt_word[BIB_PMC_BIT] = power_manager_capable;
      opt_word[BIB_ACC_MSB:BIB_ACC_LSB] = clock_accuracy;
      opt_word[BIB_REC_MSB:BIB_REC_LSB] = max_rec_code;
      opt_word[BIB_GEN_MSB:BIB_GEN_LSB] = generation;
      opt_word[BIB_SPD_MSB:BIB_SPD_LSB] = BIB_LINK_SPEED;
   end

   always_comb begin
      ctrl_word = 32'h00000000;
      ctrl_word[BIB_ROM_BIT] = rom_detected;
      ctrl_word[BIB_HILOCK_BIT] = hi_locked;
      ctrl_word[BIB_LOLOCK_BIT] = lo_locked;
      ctrl_word[BIB_LINKEN_BIT] = link_enable_control;
   end

   always_comb begin
      next_rdata = 32'h00000000;
      case (paddr)
         BIB_OPT_ADDR: next_rdata = opt_word;
         BIB_IDHI_ADDR: next_rdata = unique_id_upper_quadlet;
         BIB_IDLO_ADDR: next_rdata = unique_id_lower_quadlet;
         BIB_CTRL_ADDR: next_rdata = ctrl_word;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // One wait-free access phase: answer is ready on the first access cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : next_rdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= ~mapped;
      end else if (acc_done) begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_manager_capable <= 1'b0;
         power_manager_capable <= 1'b0;
      end else if (wr_done && paddr == BIB_OPT_ADDR) begin
         bus_manager_capable <= pwdata[BIB_BMC_BIT];
         power_manager_capable <= pwdata[BIB_PMC_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clock_accuracy <= BIB_ACC_RESET;
         generation <= BIB_GEN_RESET;
      end else if (wr_done && paddr == BIB_OPT_ADDR) begin
         clock_accuracy <= pwdata[BIB_ACC_MSB:BIB_ACC_LSB];
         generation <= pwdata[BIB_GEN_MSB:BIB_GEN_LSB];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         max_rec_code <= BIB_REC_RESET;
      end else if (wr_done && paddr == BIB_OPT_ADDR &&
                   pwdata[BIB_REC_MSB:BIB_REC_LSB] >= BIB_REC_MIN) begin
         max_rec_code <= pwdata[BIB_REC_MSB:BIB_REC_LSB];
      end
   end

   // Soft reset drops the link but keeps the bus options
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         link_enable_control <= 1'b0;
      end else if (soft_rst) begin
         link_enable_control <= 1'b0;
      end else if (wr_done && paddr == BIB_CTRL_ADDR) begin
         link_enable_control <= pwdata[BIB_LINKEN_BIT];
      end
   end

   // ROM presence is caught after release and on each host bus reset,
   // so a strap that settles late is still seen.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         started <= 1'b0;
         rom_detected <= 1'b0;
      end else begin
         started <= 1'b1;
         if (!started || host_bus_rst) begin
            rom_detected <= rom_present;
         end
      end
   end

   // load only after host bus reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         load_armed <= 1'b0;
      end else if (host_bus_rst) begin
         load_armed <= 1'b1;
      end
   end

   assign rom_we_hi = load_armed & ~host_bus_rst & rom_load_valid & rom_load_upper;
   assign rom_we_lo = load_armed & ~host_bus_rst & rom_load_valid & ~rom_load_upper;
   assign sw_we_hi = wr_done & (paddr == BIB_IDHI_ADDR);
   assign sw_we_lo = wr_done & (paddr == BIB_IDLO_ADDR);

   bib_idreg u_id_hi (
      .mclk(mclk),
      .rst(rst),
      .rom_mode(rom_detected),
      .rom_we(rom_we_hi),
      .rom_data(rom_load_data),
      .sw_we(sw_we_hi),
      .sw_data(pwdata),
      .value(unique_id_upper_quadlet),
      .locked(hi_locked)
   );

   bib_idreg u_id_lo (
      .mclk(mclk),
      .rst(rst),
      .rom_mode(rom_detected),
      .rom_we(rom_we_lo),
      .rom_data(rom_load_data),
      .sw_we(sw_we_lo),
      .sw_data(pwdata),
      .value(unique_id_lower_quadlet),
      .locked(lo_locked)
   );

   bib_blkchk u_blkchk (
      .mclk(mclk),
      .rst(rst),
      .max_rec(max_rec_code),
      .blk_len_valid(blk_len_valid),
      .blk_len(blk_len),
      .ack_type_error(ack_type_error)
   );

   // Helper copies for the checks below
   logic [31:0] last_wdata;
   logic [15:0] last_len;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_wdata <= 32'h00000000;
         last_len <= 16'h0000;
      end else begin
         last_wdata <= pwdata;
         last_len <= blk_len;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_setup(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   sequence s_wr(logic [7:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence

   property p_answer;
      psel && !penable |=> pready ##1 !pready || (psel && !penable);
   endproperty
   a_answer: assert property (p_answer)
      else $error("pready not one cycle after setup");

   property p_bmc_write;
      s_wr(BIB_OPT_ADDR) |=> bus_manager_capable == last_wdata[BIB_BMC_BIT];
   endproperty
   a_bmc_write: assert property (p_bmc_write)
      else $error("bus manager flag not written");

   property p_unused_zero;
      s_setup(BIB_OPT_ADDR) |=> (prdata & BIB_OPT_UNUSED_MASK) == 32'h00000000;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused bus options bits read nonzero");

   property p_acc_read;
      s_setup(BIB_OPT_ADDR) |=> prdata[BIB_ACC_MSB:BIB_ACC_LSB] == clock_accuracy;
   endproperty
   a_acc_read: assert property (p_acc_read)
      else $error("clock accuracy read mismatch");

   property p_rec_min;
      max_rec_code >= BIB_REC_MIN;
   endproperty
   a_rec_min: assert property (p_rec_min)
      else $error("record code below 512 bytes");

   property p_rec_soft;
      soft_rst && !wr_done |=> $stable(max_rec_code) && !link_enable_control;
   endproperty
   a_rec_soft: assert property (p_rec_soft)
      else $error("soft reset disturbed record code");

   property p_ack_err;
      blk_len_valid |=>
         ack_type_error == ({1'b0, last_len} > bib_rec_bytes(max_rec_code));
   endproperty
   a_ack_err: assert property (p_ack_err)
      else $error("ack type error mismatch");

   property p_speed;
      s_setup(BIB_OPT_ADDR) |=> prdata[BIB_SPD_MSB:BIB_SPD_LSB] == BIB_LINK_SPEED;
   endproperty
   a_speed: assert property (p_speed)
      else $error("link speed not 010");

   property p_hi_zero;
      !hi_locked |-> unique_id_upper_quadlet == BIB_ID_RESET;
   endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("upper identifier nonzero before fill");

   sequence s_rom_hi;
      rom_detected && rom_we_hi && !hi_locked;
   endsequence

   property p_rom_load;
      s_rom_hi |=> hi_locked && unique_id_upper_quadlet == $past(rom_load_data);
   endproperty
   a_rom_load: assert property (p_rom_load)
      else $error("ROM load of identifier failed");

   property p_sw_once;
      ((!rom_detected && !hi_locked) and s_wr(BIB_IDHI_ADDR)) |=>
         hi_locked && unique_id_upper_quadlet == last_wdata;
   endproperty
   a_sw_once: assert property (p_sw_once)
      else $error("software identifier write not taken");

   property p_lo_lock;
      lo_locked |=> lo_locked && $stable(unique_id_lower_quadlet);
   endproperty
   a_lo_lock: assert property (p_lo_lock)
      else $error("lower identifier changed after lock");

   property p_ignore;
      (hi_locked and s_wr(BIB_IDHI_ADDR)) |-> !pslverr ##1 $stable(unique_id_upper_quadlet);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("locked identifier write not ignored");
endmodule // bib_regs

// ===== dv/bib_rom_model.sv
`timescale 1ns/1ns
module bib_rom_model (
   input wire logic mclk,
   input wire logic go,
   input wire logic go_upper,
   input wire logic [31:0] go_data,
   input wire logic [3:0] go_wait,
   output logic rom_load_valid,
   output logic rom_load_upper,
   output logic [31:0] rom_load_data,
   output logic busy
);
   logic [3:0] cnt = 4'h0;
   logic [31:0] held = 32'h0;
   initial begin
      rom_load_valid = 1'h0;
      rom_load_upper = 1'h0;
      rom_load_data = 32'h0;
      busy = 1'h0;
   end
   always @(posedge mclk) begin
      rom_load_valid <= 1'h0;
      // Idle data toggles so a stale quadlet is never mistaken for a load
      rom_load_data <= ~rom_load_data;
      if (go) begin
         busy <= 1'h1;
         cnt <= go_wait;
         held <= go_data;
         rom_load_upper <= go_upper;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         rom_load_valid <= 1'h1;
         rom_load_data <= held;
         busy <= 1'h0;
      end
   end
endmodule // bib_rom_model

// ===== dv/bib_regs_tb.sv
`timescale 1ns/1ns
module bib_regs_tb;
   import bib_pkg::*;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ack_type_error, link_enable_control, rom_detected;
   logic soft_rst = 1'h0;
   logic host_bus_rst = 1'h0;
   logic rom_present = 1'h0;
   logic blk_len_valid = 1'h0;
   logic [15:0] blk_len = 16'h0;
   logic bus_manager_capable, power_manager_capable;
   logic [7:0] clock_accuracy;
   logic [3:0] max_rec_code;
   logic [1:0] generation;
   logic [31:0] id_hi, id_lo, rom_load_data, rd;
   logic rom_load_valid, rom_load_upper, rom_busy, err;
   logic go = 1'h0;
   logic go_upper = 1'h0;
   logic [31:0] go_data = 32'h0;
   logic [3:0] go_wait = 4'h0;
   int n_errors = 0;
   int n_tests = 0;

   always #50 mclk = ~mclk;

   bib_regs uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .soft_rst(soft_rst), .host_bus_rst(host_bus_rst), .rom_present(rom_present),
      .rom_load_valid(rom_load_valid), .rom_load_upper(rom_load_upper),
      .rom_load_data(rom_load_data), .blk_len_valid(blk_len_valid), .blk_len(blk_len),
      .ack_type_error(ack_type_error), .link_enable_control(link_enable_control),
      .bus_manager_capable(bus_manager_capable), .power_manager_capable(power_manager_capable),
      .clock_accuracy(clock_accuracy), .max_rec_code(max_rec_code), .generation(generation),
      .unique_id_upper_quadlet(id_hi), .unique_id_lower_quadlet(id_lo),
      .rom_detected(rom_detected));

   bib_rom_model rom (.mclk(mclk), .go(go), .go_upper(go_upper), .go_data(go_data),
      .go_wait(go_wait), .rom_load_valid(rom_load_valid), .rom_load_upper(rom_load_upper),
      .rom_load_data(rom_load_data), .busy(rom_busy));

   task conclude;
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task fail(input string m);
      n_errors++;
      $display("Error at %0t: %s", $time, m);
   endtask

   task chk(input logic c, input string m);
      n_tests++;
      if (c !== 1'h1) fail(m);
   endtask

   // Entered just after a rising edge; answer taken at the edge that samples pready high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'h1) fail("no pready");
      psel <= 1'h0;
      penable <= 1'h0;
      // One idle edge so a following call never reassigns psel in this step
      @(posedge mclk);
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      n_tests++;
      if (rd !== exp || err !== 1'h0) fail($sformatf("read %h got %h", a, rd));
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
      n_tests++;
      if (err !== 1'h0) fail("write error");
   endtask

   task hreset;
      rst <= 1'h1;
      repeat (12) @(posedge mclk);
      rst <= 1'h0;
      repeat (2) @(posedge mclk);
   endtask

   task rom_go(input logic u, input logic [31:0] d, input logic [3:0] w);
      int n;
      n = 0;
      go <= 1'h1;
      go_upper <= u;
      go_data <= d;
      go_wait <= w;
      @(posedge mclk);
      go <= 1'h0;
      do begin
         @(negedge mclk);
         n++;
      end while (rom_busy !== 1'h0 && n < 40);
      @(posedge mclk);
   endtask

   task t_reset_vals;
      rchk(BIB_OPT_ADDR, 32'h0000a002);
      rchk(BIB_IDHI_ADDR, 32'h0);
      rchk(BIB_IDLO_ADDR, 32'h0);
      apb(1'h0, 8'h30, 32'h0);
      chk(err === 1'h1, "unmapped no error");
      chk(max_rec_code === 4'ha, "record code reset");
   endtask

   task t_opt_fields;
      wr(BIB_OPT_ADDR, 32'hffffffff);
      rchk(BIB_OPT_ADDR, 32'h18fff0c2);
      chk(bus_manager_capable === 1'h1 && clock_accuracy === 8'hff, "field ports");
      chk(power_manager_capable === 1'h1 && generation === 2'h3, "pm and gen ports");
      // Record code 7 is below the floor and must be refused; code f is kept
      wr(BIB_OPT_ADDR, 32'h00537000);
      rchk(BIB_OPT_ADDR, 32'h0053f002);
      wr(BIB_OPT_ADDR, 32'h10008040);
      rchk(BIB_OPT_ADDR, 32'h10008042);
   endtask

   // Code 8 allows 512 bytes: only the longer packet is refused
   task t_block;
      for (int i = 0; i < 2; i++) begin
         blk_len <= 16'h0200 + 16'(i);
         blk_len_valid <= 1'h1;
         @(posedge mclk);
         blk_len_valid <= 1'h0;
         @(negedge mclk);
         chk(ack_type_error === (i == 1), "block length check");
         @(posedge mclk);
      end
   endtask

   task t_soft;
      wr(BIB_OPT_ADDR, 32'h10008080);
      wr(BIB_CTRL_ADDR, 32'h00020000);
      chk(link_enable_control === 1'h1, "link enable set");
      soft_rst <= 1'h1;
      @(posedge mclk);
      soft_rst <= 1'h0;
      @(posedge mclk);
      chk(link_enable_control === 1'h0 && max_rec_code === 4'h8, "soft reset");
      rchk(BIB_OPT_ADDR, 32'h10008082);
   endtask

   task t_write_once;
      wr(BIB_IDHI_ADDR, 32'h11223344);
      wr(BIB_IDHI_ADDR, 32'h55667788);
      rchk(BIB_IDHI_ADDR, 32'h11223344);
      wr(BIB_IDLO_ADDR, 32'h9abcdef0);
      wr(BIB_IDLO_ADDR, 32'h0);
      rchk(BIB_IDLO_ADDR, 32'h9abcdef0);
      chk(id_hi === 32'h11223344 && id_lo === 32'h9abcdef0, "id ports");
      rchk(BIB_CTRL_ADDR, 32'h00000006);
   endtask

   task t_rom;
      rom_present <= 1'h1;
      hreset();
      rchk(BIB_IDHI_ADDR, 32'h0);
      chk(rom_detected === 1'h1, "rom not detected");
      wr(BIB_IDHI_ADDR, 32'h00000001);
      host_bus_rst <= 1'h1;
      @(posedge mclk);
      host_bus_rst <= 1'h0;
      @(posedge mclk);
      rom_go(1'h1, 32'hc0ffee01, 4'h0);
      rom_go(1'h0, 32'h2468ace0, 4'h5);
      rchk(BIB_IDHI_ADDR, 32'hc0ffee01);
      rchk(BIB_IDLO_ADDR, 32'h2468ace0);
      rom_go(1'h1, 32'h0, 4'h2);
      wr(BIB_IDLO_ADDR, 32'h0);
      rchk(BIB_IDHI_ADDR, 32'hc0ffee01);
      rchk(BIB_IDLO_ADDR, 32'h2468ace0);
      rchk(BIB_CTRL_ADDR, 32'h00000007);
   endtask

   initial begin
      hreset();
      t_reset_vals();
      t_opt_fields();
      t_block();
      t_soft();
      t_write_once();
      t_rom();
      conclude();
   end

   // Whole run is under two hundred cycles
   initial begin
      repeat (5000) @(posedge mclk);
      fail("timeout");
      conclude();
   end
endmodule // bib_regs_tb
